// ### dv/bfd_decoder_tb_top.sv
// Self-checking testbench for the byte-file instruction decoder.
`timescale 1ns/1ns
module bfd_decoder_tb_top;
  import bfd_pkg::*;
  logic        clk, rst_b, cond_set;
  logic        prescale_on, word_valid, cond_true, dec_valid;
  logic [3:0]  bank_ptr;
  logic [15:0] word;
  bfd_op_t     op;
  logic        dest_file, fast_ret, is_cond, pc_change, use_pins, clr_ps;
  logic [11:0] file_addr, move_dst;
  logic [2:0]  bit_sel;
  logic [7:0]  literal;
  logic [19:0] target;
  logic [10:0] br_offset;
  logic [4:0]  flag_upd;
  int          n_errors = 0, n_checks = 0;

  always #2 clk = ~clk;

  bfd_fetch_model fetch_u (.clk(clk), .rst_b(rst_b), .cond_set(cond_set),
    .dec_valid(dec_valid), .is_cond(is_cond), .word_valid(word_valid),
    .word(word), .cond_true(cond_true));

  bfd_decoder dut_u (.CORE_CLK(clk), .RST_B(rst_b),
    .WORD_VALID(word_valid), .WORD_IN(word), .BANK_PTR(bank_ptr),
    .COND_TRUE(cond_true), .PRESCALE_ON(prescale_on),
    .DEC_VALID(dec_valid), .OP(op), .DEST_FILE(dest_file),
    .FILE_ADDR(file_addr), .MOVE_DST(move_dst), .BIT_SEL(bit_sel),
    .LITERAL(literal), .TARGET(target), .FAST_RET(fast_ret),
    .BR_OFFSET(br_offset), .FLAG_UPD(flag_upd), .IS_COND(is_cond),
    .PC_CHANGE(pc_change), .USE_PINS(use_pins), .CLR_PRESCALE(clr_ps));

  task automatic chk(input logic [19:0] seen, exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask

  // Waits a bounded number of cycles for the next decoded operation.
  task automatic next_dec();
    int k;
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (dec_valid !== 1'b1 && k < 20);
    chk(dec_valid, 1, "no decode");
  endtask

  task automatic test_byte_ops();
    logic [15:0] tpl [30] = '{16'h2400, 16'h2000, 16'h1400, 16'h1000,
      16'h1800, 16'h1C00, 16'h0400, 16'h2800, 16'h3400, 16'h3000, 16'h4400,
      16'h4000, 16'h5C00, 16'h5800, 16'h5400, 16'h2C00, 16'h4C00, 16'h3C00,
      16'h4800, 16'h0200, 16'h6200, 16'h6400, 16'h6000, 16'h5000, 16'h3800,
      16'h6A00, 16'h6800, 16'h6C00, 16'h6E00, 16'h6600};
    bfd_op_t ops [30] = '{OP_ADD, OP_ADDC, OP_AND, OP_IOR, OP_XOR, OP_COM,
      OP_DEC, OP_INC, OP_RLC, OP_RRC, OP_RLN, OP_RRN, OP_SUB, OP_SUBB,
      OP_SUBFB, OP_DECSZ, OP_DECSNZ, OP_INCSZ, OP_INCSNZ, OP_MUL, OP_CPEQ,
      OP_CPGT, OP_CPLT, OP_MOVF, OP_SWAP, OP_CLR, OP_SET, OP_NEG, OP_MOVWF,
      OP_TST};
    logic [4:0] fl [30] = '{5'h1F, 5'h1F, 5'h14, 5'h14, 5'h14, 5'h14,
      5'h1F, 5'h1F, 5'h15, 5'h15, 5'h14, 5'h14, 5'h1F, 5'h1F, 5'h1F,
      5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h14,
      5'h00, 5'h04, 5'h00, 5'h1F, 5'h00, 5'h00};
    logic [7:0]  f;
    logic        d;
    logic        a;
    logic        hd;
    logic        ic;
    logic [11:0] ea;
    for (int i = 0; i < 30; i++) begin
      hd = i < 19 || i == 23 || i == 24;
      f = 8'h10 + 8'(i * 8);
      fetch_u.push(tpl[i] | {6'h00, i[0] && hd, i[1], f});
    end
    for (int i = 0; i < 30; i++) begin
      hd = i < 19 || i == 23 || i == 24;
      ic = (i >= 15 && i <= 22 && i != 19) || i == 29;
      d = i[0] && hd;
      a = i[1];
      f = 8'h10 + 8'(i * 8);
      ea = a ? {4'h7, f} : {(f < 8'h60) ? 4'h0 : 4'hF, f};
      next_dec();
      chk(op, ops[i], "operation");
      chk(flag_upd, fl[i], "flags");
      chk(file_addr, ea, "file address");
      if (hd) chk(dest_file, d, "destination");
      chk(is_cond, ic, "skip class");
    end
    $display("byte operations done");
  endtask

  task automatic test_two_word();
    logic [15:0] w [12] = '{16'hC123, 16'hF456, 16'hEF5A, 16'hF9BC,
      16'h2410, 16'hED33, 16'hF001, 16'h0000, 16'hF0FF, 16'hD7FF, 16'h0000,
      16'hE080};
    foreach (w[i]) fetch_u.push(w[i]);
    fetch_u.push(16'h0E7F);
    fetch_u.push(16'h9B45);
    next_dec();
    chk(op, OP_FILE_TO_FILE_MOVE, "move op");
    chk({file_addr, 8'h00}, {12'h123, 8'h00}, "move source");
    chk(move_dst, 12'h456, "move destination");
    chk(flag_upd, 5'h00, "move flags");
    next_dec();
    chk(op, OP_GOTO, "jump op");
    chk(target, 20'h9BC5A, "jump target");
    chk(pc_change, 1, "jump pc");
    next_dec();
    chk(op, OP_NOP, "flush after jump");
    next_dec();
    chk(op, OP_CALL, "call op");
    chk(fast_ret, 1, "fast bit");
    chk(target, 20'h00133, "call target");
    next_dec();
    next_dec();
    chk(op, OP_NOP, "lone second word");
    chk(flag_upd, 5'h00, "lone word flags");
    next_dec();
    chk(op, OP_BRA, "branch op");
    chk(br_offset, 11'h7FF, "branch offset");
    next_dec();
    next_dec();
    chk(br_offset, 11'h780, "conditional offset");
    next_dec();
    chk(literal, 8'h7F, "literal");
    next_dec();
    chk(bit_sel, 3'h5, "bit select");
    chk(file_addr, 12'h745, "bit address");
    $display("two-word and control done");
  endtask

  task automatic test_skip_side();
    @(posedge clk);
    prescale_on <= 1'b1;
    cond_set    <= 1'b1;
    bank_ptr    <= 4'h3;
    #1;
    fetch_u.push(16'h2E30);
    fetch_u.push(16'h2610);
    fetch_u.push(16'h26D0);
    fetch_u.push(16'h2685);
    fetch_u.push(16'h2485);
    fetch_u.push(16'h2185);
    next_dec();
    chk(is_cond, 1, "skip shown");
    next_dec();
    chk(op, OP_NOP, "skipped word");
    chk(flag_upd, 5'h00, "skipped flags");
    next_dec();
    chk(clr_ps, 1, "prescale clear");
    next_dec();
    chk(use_pins, 1, "pin source");
    chk(clr_ps, 0, "no prescale clear");
    next_dec();
    chk(use_pins, 0, "latch source");
    next_dec();
    chk(op, OP_ADDC, "banked add");
    chk(file_addr, 12'h385, "second bank");
    chk(clr_ps, 0, "no timer address");
    $display("skip and side effects done");
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    clk         = 1'b0;
    rst_b       = 1'b0;
    cond_set    = 1'b0;
    prescale_on = 1'b0;
    bank_ptr    = 4'h7;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    chk(dec_valid, 0, "idle after reset");
    test_byte_ops();
    test_two_word();
    test_skip_side();
    wrap_up();
  end

  initial begin
    #20000;
    n_errors++;
    $display("watchdog expired");
    wrap_up();
  end
endmodule

// ### dv/bfd_fetch_model.sv
// Program memory fetch and datapath condition source for the decoder.
`timescale 1ns/1ns
module bfd_fetch_model (
  input  wire logic        clk,        // Core clock
  input  wire logic        rst_b,      // Async reset, active low
  input  wire logic        cond_set,   // Condition result to report
  input  wire logic        dec_valid,  // Decoder output strobe
  input  wire logic        is_cond,    // Conditional op shown
  output logic             word_valid, // Program word present
  output logic      [15:0] word,       // Program word
  output logic             cond_true   // Condition answer
);
  logic [15:0] words_q[$];
  logic        noise_q = 1'b0;

  task automatic push(input logic [15:0] w);
    words_q.push_back(w);
  endtask

  // Idle word lines keep changing so a stale word is never mistaken.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      word_valid <= 1'b0;
      word       <= 16'h0000;
    end else if (words_q.size() > 0) begin
      word_valid <= 1'b1;
      word       <= words_q.pop_front();
    end else begin
      word_valid <= 1'b0;
      word       <= ~word;
    end
  end

  always @(posedge clk) begin
    noise_q <= ~noise_q;
  end

  // The answer only means something while a conditional op is shown.
  assign cond_true = (dec_valid && is_cond) ? cond_set : noise_q;
endmodule

// ### shared/bfd_pkg.sv
// Shared constants and types for the byte-file instruction decoder.
package bfd_pkg;

  // ----------------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------------
  localparam int unsigned POS_D      = 9;
  localparam int unsigned POS_A      = 8;
  localparam int unsigned POS_S      = 8;
  localparam int unsigned BIT_LSB    = 9;
  localparam logic [15:0] WORD_NOP   = 16'h0000;
  localparam logic [3:0]  NIB_SECOND = 4'hF;
  localparam logic [3:0]  NIB_FILE_TO_FILE_MOVE  = 4'hC;
  localparam logic [3:0]  NIB_BIT_LO = 4'h7;
  localparam logic [3:0]  NIB_BIT_HI = 4'hB;
  localparam logic [7:0]  CTL_GOTO   = 8'hEF;
  localparam logic [6:0]  CTL_CALL   = 7'h76;
  localparam logic [4:0]  CTL_BRA    = 5'h1A;
  localparam logic [4:0]  CTL_BCOND  = 5'h1C;
  localparam logic [4:0]  CTL_LIT    = 5'h01;

  // ----------------------------------------------------------------------
  // Byte-oriented opcodes, bits 15:10 and 15:9
  // ----------------------------------------------------------------------
  localparam logic [5:0] OPC_ADD    = 6'h09;
  localparam logic [5:0] OPC_ADDC   = 6'h08;
  localparam logic [5:0] OPC_AND    = 6'h05;
  localparam logic [5:0] OPC_IOR    = 6'h04;
  localparam logic [5:0] OPC_XOR    = 6'h06;
  localparam logic [5:0] OPC_COM    = 6'h07;
  localparam logic [5:0] OPC_DEC    = 6'h01;
  localparam logic [5:0] OPC_DECSZ  = 6'h0B;
  localparam logic [5:0] OPC_DECSNZ = 6'h13;
  localparam logic [5:0] OPC_INC    = 6'h0A;
  localparam logic [5:0] OPC_INCSZ  = 6'h0F;
  localparam logic [5:0] OPC_INCSNZ = 6'h12;
  localparam logic [5:0] OPC_RLC    = 6'h0D;
  localparam logic [5:0] OPC_RRC    = 6'h0C;
  localparam logic [5:0] OPC_RLN    = 6'h11;
  localparam logic [5:0] OPC_RRN    = 6'h10;
  localparam logic [5:0] OPC_SUB    = 6'h17;
  localparam logic [5:0] OPC_SUBB   = 6'h16;
  localparam logic [5:0] OPC_SUBFB  = 6'h15;
  localparam logic [5:0] OPC_MOVF   = 6'h14;
  localparam logic [5:0] OPC_SWAP   = 6'h0E;
  localparam logic [6:0] OPC_CPEQ   = 7'h31;
  localparam logic [6:0] OPC_CPGT   = 7'h32;
  localparam logic [6:0] OPC_CPLT   = 7'h30;
  localparam logic [6:0] OPC_MUL    = 7'h01;
  localparam logic [6:0] OPC_CLR    = 7'h35;
  localparam logic [6:0] OPC_SET    = 7'h34;
  localparam logic [6:0] OPC_NEG    = 7'h36;
  localparam logic [6:0] OPC_MOVWF  = 7'h37;
  localparam logic [6:0] OPC_TST    = 7'h33;

  // ----------------------------------------------------------------------
  // Status flags: carry, digit carry, zero, overflow, negative
  // ----------------------------------------------------------------------
  localparam logic [4:0] FM_ALL  = 5'h1F;
  localparam logic [4:0] FM_CZN  = 5'h15;
  localparam logic [4:0] FM_ZN   = 5'h14;
  localparam logic [4:0] FM_Z    = 5'h04;
  localparam logic [4:0] FM_NONE = 5'h00;

  // ----------------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------------
  localparam logic [7:0]  ACCESS_SPLIT = 8'h60;
  localparam logic [3:0]  BANK_LOW     = 4'h0;
  localparam logic [3:0]  BANK_HIGH    = 4'hF;
  localparam logic [11:0] TIMER_ADDR   = 12'hFD0;
  localparam logic [11:0] PORT_LO      = 12'hF80;
  localparam logic [11:0] PORT_HI      = 12'hF8F;

  typedef enum logic [5:0] {
    OP_NOP, OP_ADD, OP_ADDC, OP_AND, OP_IOR, OP_XOR, OP_COM,
    OP_CPEQ, OP_CPGT, OP_CPLT, OP_DEC, OP_DECSZ, OP_DECSNZ,
    OP_INC, OP_INCSZ, OP_INCSNZ, OP_RLC, OP_RRC, OP_RLN, OP_RRN,
    OP_SUB, OP_SUBB, OP_SUBFB, OP_MUL, OP_CLR, OP_SET, OP_MOVF,
    OP_MOVWF, OP_NEG, OP_SWAP, OP_TST, OP_FILE_TO_FILE_MOVE, OP_GOTO, OP_CALL,
    OP_BRA, OP_BCOND, OP_LIT, OP_BIT, OP_OTHER
  } bfd_op_t;

  typedef enum logic [1:0] {ST_FIRST, ST_SECOND, ST_FLUSH} bfd_st_t;

endpackage

// ### verilog/bfd_addr_gen.sv
// File register address builder from bank access bit and bank pointer.
`timescale 1ns/1ns
module bfd_addr_gen (
  input  wire logic [15:0] word,      // Instruction word
  input  wire logic [3:0]  bank_ptr,  // Bank pointer register value
  output logic      [11:0] file_addr  // Full 12-bit file address
);
  import bfd_pkg::*;

  logic [7:0] low_byte;
  logic [3:0] access_bank;

  assign low_byte = word[7:0];

  // Low part of the access bank maps to bank 0, the rest to the top bank.
  assign access_bank = (low_byte < ACCESS_SPLIT) ? BANK_LOW : BANK_HIGH;

  always_comb begin
    if (word[POS_A]) begin
      file_addr = {bank_ptr, low_byte};
    end else begin
      file_addr = {access_bank, low_byte};
    end
  end

endmodule

// ### verilog/bfd_decoder.sv
// Byte-file instruction decoder: formats, byte operations, two-word handling.
`timescale 1ns/1ns
module bfd_decoder (
  input  wire logic             CORE_CLK,     // Core clock, 250 MHz
  input  wire logic             RST_B,        // Async reset, active low
  input  wire logic             WORD_VALID,   // Program word present
  input  wire logic [15:0]      WORD_IN,      // Program word
  input  wire logic [3:0]       BANK_PTR,     // Bank pointer register
  input  wire logic             COND_TRUE,    // Test of shown op is true
  input  wire logic             PRESCALE_ON,  // Prescaler is on timer
  output logic                  DEC_VALID,    // Decoded op present
  output bfd_pkg::bfd_op_t      OP,           // Decoded operation
  output logic                  DEST_FILE,    // Result to file register
  output logic      [11:0]      FILE_ADDR,    // File or move source addr
  output logic      [11:0]      MOVE_DST,     // File move destination
  output logic      [2:0]       BIT_SEL,      // Bit number
  output logic      [7:0]       LITERAL,      // Immediate byte
  output logic      [19:0]      TARGET,       // Jump or call target
  output logic                  FAST_RET,     // Call fast bit
  output logic      [10:0]      BR_OFFSET,    // Signed branch offset
  output logic      [4:0]       FLAG_UPD,     // C, DC, Z, OV, N updates
  output logic                  IS_COND,      // Conditional op shown
  output logic                  PC_CHANGE,    // Op alters the PC
  output logic                  USE_PINS,     // Read port pins as source
  output logic                  CLR_PRESCALE  // Clear timer prescaler
);
  import bfd_pkg::*;

  // ----------------------------------------------------------------------
  // Word classification
  // ----------------------------------------------------------------------
  function automatic bfd_op_t op_of(input logic [15:0] w);
    bfd_op_t o;
    o = OP_OTHER;
    if (w == WORD_NOP) begin
      o = OP_NOP;
    end else if (w[15:12] == NIB_SECOND) begin
      o = OP_NOP;
    end else if (w[15:12] == NIB_FILE_TO_FILE_MOVE) begin
      o = OP_FILE_TO_FILE_MOVE;
    end else if (w[15:8] == CTL_GOTO) begin
      o = OP_GOTO;
    end else if (w[15:9] == CTL_CALL) begin
      o = OP_CALL;
    end else if (w[15:11] == CTL_BRA) begin
      o = OP_BRA;
    end else if (w[15:11] == CTL_BCOND) begin
      o = OP_BCOND;
    end else if (w[15:11] == CTL_LIT) begin
      o = OP_LIT;
    end else if (w[15:12] >= NIB_BIT_LO && w[15:12] <= NIB_BIT_HI) begin
      o = OP_BIT;
    end else begin
      case (w[15:10])
        OPC_ADD:    o = OP_ADD;
        OPC_ADDC:   o = OP_ADDC;
        OPC_AND:    o = OP_AND;
        OPC_IOR:    o = OP_IOR;
        OPC_XOR:    o = OP_XOR;
        OPC_COM:    o = OP_COM;
        OPC_DEC:    o = OP_DEC;
        OPC_DECSZ:  o = OP_DECSZ;
        OPC_DECSNZ: o = OP_DECSNZ;
        OPC_INC:    o = OP_INC;
        OPC_INCSZ:  o = OP_INCSZ;
        OPC_INCSNZ: o = OP_INCSNZ;
        OPC_RLC:    o = OP_RLC;
        OPC_RRC:    o = OP_RRC;
        OPC_RLN:    o = OP_RLN;
        OPC_RRN:    o = OP_RRN;
        OPC_SUB:    o = OP_SUB;
        OPC_SUBB:   o = OP_SUBB;
        OPC_SUBFB:  o = OP_SUBFB;
        OPC_MOVF:   o = OP_MOVF;
        OPC_SWAP:   o = OP_SWAP;
        default:    o = OP_OTHER;
      endcase
      if (o == OP_OTHER) begin
        case (w[15:9])
          OPC_CPEQ:  o = OP_CPEQ;
          OPC_CPGT:  o = OP_CPGT;
          OPC_CPLT:  o = OP_CPLT;
          OPC_MUL:   o = OP_MUL;
          OPC_CLR:   o = OP_CLR;
          OPC_SET:   o = OP_SET;
          OPC_NEG:   o = OP_NEG;
          OPC_MOVWF: o = OP_MOVWF;
          OPC_TST:   o = OP_TST;
          default:   o = OP_OTHER;
        endcase
      end
    end
    return o;
  endfunction

  bfd_st_t     st_q;
  bfd_op_t     word_op;
  bfd_op_t     hold_op_q;
  logic [11:0] eff_addr;
  logic [4:0]  map_flags;
  logic        map_skip;
  logic        map_tmr;
  logic        map_has_d;
  logic        squash;
  logic        nop_now;
  logic        first_take;
  logic        second_take;
  logic        two_word;
  logic        in_ports;

  assign word_op = op_of(WORD_IN);

  bfd_addr_gen u_addr (
    .word      (WORD_IN),
    .bank_ptr  (BANK_PTR),
    .file_addr (eff_addr)
  );

  bfd_flag_map u_flags (
    .op     (word_op),
    .flags  (map_flags),
    .skip   (map_skip),
    .tmr_fx (map_tmr),
    .has_d  (map_has_d)
  );

  // A true test on the shown op turns the word taken now into a NOP.
  assign squash      = DEC_VALID && IS_COND && COND_TRUE;
  assign nop_now     = (st_q == ST_FLUSH) || squash;
  assign first_take  = WORD_VALID && (st_q == ST_FIRST) && !squash;
  assign second_take = WORD_VALID && (st_q == ST_SECOND);
  assign two_word    = (word_op == OP_FILE_TO_FILE_MOVE) || (word_op == OP_GOTO) ||
                       (word_op == OP_CALL);
  assign in_ports    = (eff_addr >= PORT_LO) && (eff_addr <= PORT_HI);

  // ----------------------------------------------------------------------
  // Sequencing of two-word and flushed words
  // ----------------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_q      <= ST_FIRST;
      hold_op_q <= OP_NOP;
    end else if (squash && !WORD_VALID) begin
      st_q <= ST_FLUSH;
    end else if (WORD_VALID) begin
      case (st_q)
        ST_FIRST: begin
          if (squash) begin
            st_q <= ST_FIRST;
          end else if (two_word) begin
            st_q      <= ST_SECOND;
            hold_op_q <= word_op;
          end else if (word_op == OP_BRA) begin
            st_q <= ST_FLUSH;
          end
        end
        ST_SECOND: begin
          if (hold_op_q == OP_FILE_TO_FILE_MOVE) begin
            st_q <= ST_FIRST;
          end else begin
            st_q <= ST_FLUSH;
          end
        end
        default: st_q <= ST_FIRST;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Operation, flag and side-effect outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      DEC_VALID    <= 1'b0;
      OP           <= OP_NOP;
      FLAG_UPD     <= FM_NONE;
      IS_COND      <= 1'b0;
      PC_CHANGE    <= 1'b0;
      USE_PINS     <= 1'b0;
      CLR_PRESCALE <= 1'b0;
    end else begin
      DEC_VALID    <= 1'b0;
      IS_COND      <= 1'b0;
      PC_CHANGE    <= 1'b0;
      USE_PINS     <= 1'b0;
      CLR_PRESCALE <= 1'b0;
      FLAG_UPD     <= FM_NONE;
      if (WORD_VALID && nop_now) begin
        DEC_VALID <= 1'b1;
        OP        <= OP_NOP;
      end else if (second_take) begin
        DEC_VALID <= 1'b1;
        OP        <= hold_op_q;
        PC_CHANGE <= (hold_op_q != OP_FILE_TO_FILE_MOVE);
      end else if (first_take && !two_word) begin
        DEC_VALID <= 1'b1;
        OP        <= word_op;
        FLAG_UPD  <= map_flags;
        IS_COND   <= map_skip || (word_op == OP_BCOND);
        PC_CHANGE <= (word_op == OP_BRA);
        USE_PINS  <= map_has_d && WORD_IN[POS_D] && in_ports;
        CLR_PRESCALE <= map_tmr && PRESCALE_ON &&
                        (eff_addr == TIMER_ADDR) &&
                        (!map_has_d || WORD_IN[POS_D]);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Operand fields
  // ----------------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      DEST_FILE <= 1'b0;
      FILE_ADDR <= 12'h000;
      BIT_SEL   <= 3'h0;
      LITERAL   <= 8'h00;
      FAST_RET  <= 1'b0;
      BR_OFFSET <= 11'h000;
    end else if (first_take) begin
      DEST_FILE <= WORD_IN[POS_D];
      BIT_SEL   <= WORD_IN[BIT_LSB +: 3];
      LITERAL   <= WORD_IN[7:0];
      FAST_RET  <= WORD_IN[POS_S];
      if (word_op == OP_FILE_TO_FILE_MOVE) begin
        FILE_ADDR <= WORD_IN[11:0];
      end else begin
        FILE_ADDR <= eff_addr;
      end
      if (word_op == OP_BRA) begin
        BR_OFFSET <= WORD_IN[10:0];
      end else begin
        BR_OFFSET <= {{3{WORD_IN[7]}}, WORD_IN[7:0]};
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      TARGET   <= 20'h00000;
      MOVE_DST <= 12'h000;
    end else if (first_take) begin
      TARGET[7:0] <= WORD_IN[7:0];
    end else if (second_take) begin
      TARGET[19:8] <= WORD_IN[11:0];
      MOVE_DST     <= WORD_IN[11:0];
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);

  a_dest_route: assert property (
    first_take && map_has_d && !two_word
    |=> DEC_VALID && DEST_FILE == $past(WORD_IN[POS_D]))
    else $error("destination bit not routed");

  a_bank_pick: assert property (
    first_take && WORD_IN[POS_A] && word_op != OP_FILE_TO_FILE_MOVE
    |=> FILE_ADDR == {$past(BANK_PTR), $past(WORD_IN[7:0])})
    else $error("bank pointer not used for banked access");

  a_low_addr: assert property (
    first_take && word_op == OP_BIT
    |=> FILE_ADDR[7:0] == $past(WORD_IN[7:0]) && OP == OP_BIT)
    else $error("file address not from low byte");

  a_move_pair: assert property (
    second_take && hold_op_q == OP_FILE_TO_FILE_MOVE
    |=> DEC_VALID && OP == OP_FILE_TO_FILE_MOVE && FLAG_UPD == FM_NONE &&
        MOVE_DST == $past(WORD_IN[11:0]))
    else $error("two-word move not completed");

  a_bit_field: assert property (
    first_take |=> BIT_SEL == $past(WORD_IN[11:9]))
    else $error("bit select field wrong");

  a_literal_byte: assert property (
    first_take && word_op == OP_LIT |=> LITERAL == $past(WORD_IN[7:0]))
    else $error("literal byte wrong");

  a_long_target: assert property (
    second_take && hold_op_q != OP_FILE_TO_FILE_MOVE
    |=> TARGET[19:8] == $past(WORD_IN[11:0]) && PC_CHANGE)
    else $error("jump target high part wrong");

  a_branch_offset: assert property (
    first_take && word_op == OP_BRA
    |=> BR_OFFSET == $past(WORD_IN[10:0]) && st_q == ST_FLUSH)
    else $error("branch offset wrong");

  a_arith_flags: assert property (
    DEC_VALID && (OP == OP_ADD || OP == OP_ADDC || OP == OP_SUB)
    |-> FLAG_UPD == FM_ALL)
    else $error("arithmetic flags not all updated");

  a_logic_flags: assert property (
    DEC_VALID && (OP == OP_AND || OP == OP_XOR || OP == OP_RLN)
    |-> FLAG_UPD == FM_ZN)
    else $error("logical flags wrong");

  a_skip_quiet: assert property (
    DEC_VALID && (OP == OP_CPEQ || OP == OP_DECSZ || OP == OP_INCSNZ)
    |-> FLAG_UPD == FM_NONE && IS_COND)
    else $error("skip op changed flags");

  a_mul_quiet: assert property (
    DEC_VALID && OP == OP_MUL |-> FLAG_UPD == FM_NONE)
    else $error("multiply changed flags");

  a_squash_nop: assert property (
    squash && WORD_VALID |=> DEC_VALID && OP == OP_NOP && !IS_COND)
    else $error("word after true test not a NOP");

  a_lone_second: assert property (
    first_take && WORD_IN[15:12] == NIB_SECOND
    |=> DEC_VALID && OP == OP_NOP && FLAG_UPD == FM_NONE)
    else $error("lone second word not a NOP");

  c_move_done: cover property (DEC_VALID && OP == OP_FILE_TO_FILE_MOVE);
  c_skip_taken: cover property (squash ##1 DEC_VALID && OP == OP_NOP);
  c_call_fast: cover property (DEC_VALID && OP == OP_CALL && FAST_RET);
  c_prescale: cover property (CLR_PRESCALE);

endmodule

// ### verilog/bfd_flag_map.sv
// Status flag, skip and side-effect classes of each decoded operation.
`timescale 1ns/1ns
module bfd_flag_map (
  input  wire bfd_pkg::bfd_op_t op,     // Decoded operation
  output logic [4:0]            flags,  // Flags the operation updates
  output logic                  skip,   // Conditional skip operation
  output logic                  tmr_fx, // May clear the timer prescaler
  output logic                  has_d   // Carries a destination bit
);
  import bfd_pkg::*;

  always_comb begin
    flags  = FM_NONE;
    skip   = 1'b0;
    tmr_fx = 1'b0;
    has_d  = 1'b0;
    case (op)
      OP_ADD, OP_ADDC, OP_DEC, OP_INC, OP_SUB: begin
        flags  = FM_ALL;
        tmr_fx = 1'b1;
        has_d  = 1'b1;
      end
      OP_SUBB, OP_SUBFB: begin
        flags = FM_ALL;
        has_d = 1'b1;
      end
      OP_AND, OP_IOR, OP_COM, OP_RLN, OP_RRN, OP_XOR, OP_MOVF: begin
        flags  = FM_ZN;
        tmr_fx = (op == OP_AND) || (op == OP_IOR) || (op == OP_COM);
        has_d  = 1'b1;
      end
      OP_RLC, OP_RRC: begin
        flags  = FM_CZN;
        tmr_fx = (op == OP_RLC);
        has_d  = 1'b1;
      end
      OP_DECSZ, OP_DECSNZ, OP_INCSZ, OP_INCSNZ: begin
        skip   = 1'b1;
        tmr_fx = (op != OP_INCSZ);
        has_d  = 1'b1;
      end
      OP_CPEQ, OP_CPGT, OP_CPLT, OP_TST: begin
        skip   = 1'b1;
        tmr_fx = (op == OP_CPLT) || (op == OP_TST);
      end
      OP_MUL:  tmr_fx = 1'b1;
      OP_CLR: begin
        flags  = FM_Z;
        tmr_fx = 1'b1;
      end
      OP_SET:  tmr_fx = 1'b1;
      OP_NEG:  flags = FM_ALL;
      OP_SWAP: has_d = 1'b1;
      default: flags = FM_NONE;
    endcase
  end

endmodule
